//--- common/cscr_consts.svh
// Addresses, field positions, reset values and sizes of the CPU system registers
`ifndef CSCR_CONSTS_SVH
`define CSCR_CONSTS_SVH

`define CSCR_ADDR_ICR     8'he6
`define CSCR_ADDR_FLG     8'he7
`define CSCR_ADDR_RP0     8'he8
`define CSCR_ADDR_RP1     8'he9

`define CSCR_ICR_RST      8'h87
`define CSCR_FLG_RST      8'h00
`define CSCR_RP_RST       8'h00

`define CSCR_ICR_GATE     7
`define CSCR_ICR_PEND     6
`define CSCR_ICR_TLMODE   5
`define CSCR_ICR_ALLOW    4
`define CSCR_ICR_ARB      3

`define CSCR_FLG_C        7
`define CSCR_FLG_Z        6
`define CSCR_FLG_S        5
`define CSCR_FLG_V        4
`define CSCR_FLG_DA       3
`define CSCR_FLG_H        2
`define CSCR_FLG_RSV      1
`define CSCR_FLG_MEM      0
`define CSCR_FLG_WMASK    8'hfd

`define CSCR_RP_WMASK     8'hfc
`define CSCR_STACK_DEPTH  7
`define CSCR_DEPTH_MAX    3'h7
`define CSCR_GROUP_D      4'hd

`endif

//--- common/cscr_pkg.sv
// Types shared by the CPU system register block and its flag unit
`default_nettype none
`include "cscr_consts.svh"

package cscr_pkg;

  typedef enum logic [1:0] {
    CSCR_C_KEEP, CSCR_C_SET, CSCR_C_CLR, CSCR_C_CPL
  } cscr_carry_op_t;

  typedef enum logic [1:0] {
    CSCR_M_KEEP, CSCR_M_DATA, CSCR_M_CODE
  } cscr_mem_op_t;

  typedef enum logic [1:0] {
    CSCR_P_NONE, CSCR_P_SINGLE, CSCR_P_LOW, CSCR_P_HIGH
  } cscr_ptr_op_t;

  // Result of one ALU instruction as seen by the flag logic
  typedef struct packed {
    logic        upd;
    logic        word;
    logic        aff_c;
    logic        arith;
    logic        sub;
    logic [16:0] res;
    logic        ovf;
    logic        half;
  } cscr_alu_op_t;

  typedef struct packed {
    cscr_alu_op_t   alu;
    cscr_carry_op_t c_op;
    cscr_mem_op_t   m_op;
  } cscr_flag_cmd_t;

  typedef struct packed {
    logic       gate;
    logic       pend;
    logic       tl_mode;
    logic       allow;
    logic       arb;
    logic [2:0] cpl;
  } cscr_icr_t;

  typedef struct packed {
    logic [4:0] blk;
    logic       pointer_mode_sel;
    logic [1:0] rsv;
  } cscr_ptr_t;

  typedef struct packed {
    cscr_icr_t                             icr;
    logic [7:0]                            flags;
    cscr_ptr_t                             rp0;
    cscr_ptr_t                             rp1;
    logic [`CSCR_STACK_DEPTH-1:0][7:0]     stack;
    logic [2:0]                            depth;
    logic [7:0]                            rdata;
    logic                                  rvalid;
    logic                                  nest_save;
    logic [2:0]                            nest_level;
  } cscr_state_t;

endpackage

`default_nettype wire

//--- rtl/cscr_flag_unit.sv
// Next-value logic of the CPU flag register for ALU and flag instructions
`default_nettype none
`include "cscr_consts.svh"

module cscr_flag_unit
  import cscr_pkg::*;
(
  input  wire logic [7:0]     flags_cur,
  input  wire cscr_flag_cmd_t cmd,
  output logic [7:0]          flags_next
);

  always_comb begin
    flags_next = flags_cur;
    if (cmd.alu.upd) begin
      if (cmd.alu.aff_c) begin
        flags_next[`CSCR_FLG_C] = cmd.alu.word ? cmd.alu.res[16]
                                               : cmd.alu.res[8]; // RULE12
      end
      flags_next[`CSCR_FLG_Z] = cmd.alu.word
                                ? (cmd.alu.res[15:0] == 16'h0000)
                                : (cmd.alu.res[7:0] == 8'h00); // RULE13
      flags_next[`CSCR_FLG_S] = cmd.alu.word ? cmd.alu.res[15]
                                             : cmd.alu.res[7]; // RULE14
      flags_next[`CSCR_FLG_V] = cmd.alu.ovf; // RULE15
      if (cmd.alu.arith) begin
        flags_next[`CSCR_FLG_DA] = cmd.alu.sub; // RULE16
        flags_next[`CSCR_FLG_H]  = cmd.alu.half; // RULE17
      end
    end
    // Dedicated carry instructions come after the ALU update on purpose
    unique case (cmd.c_op)
      CSCR_C_KEEP: ;
      CSCR_C_SET:  flags_next[`CSCR_FLG_C] = 1'b1; // RULE12
      CSCR_C_CLR:  flags_next[`CSCR_FLG_C] = 1'b0; // RULE12
      CSCR_C_CPL:  flags_next[`CSCR_FLG_C] = ~flags_cur[`CSCR_FLG_C]; // RULE12
    endcase
    unique case (cmd.m_op)
      CSCR_M_KEEP: ;
      CSCR_M_DATA: flags_next[`CSCR_FLG_MEM] = 1'b1; // RULE18
      CSCR_M_CODE: flags_next[`CSCR_FLG_MEM] = 1'b0; // RULE18
      default:     ;
    endcase
    flags_next[`CSCR_FLG_RSV] = 1'b0; // RULE17
  end

endmodule

`default_nettype wire

//--- rtl/cscr_regs.sv
// CPU system registers: interrupt control, flags and working pointers
`default_nettype none
`include "cscr_consts.svh"

// Behaviour
// RULE1: Timer gate resets to one; a timer runs when gate and its allow bit.
// RULE2: Top-level pending set by recognised request or by software writing one.
// RULE3: Top-level ack uses mask select only, or also global allow when mode one.
// RULE4: Ack clears global allow; return and unmask set it; mask instr clears.
// RULE5: Software writes global allow only when nothing pending; mask first.
// RULE6: Global allow zero blocks every source except the top-level one; the code also blocks the top-level one when mode is one.
// RULE7: Arbitration bit zero concurrent, one nested; only software changes it.
// RULE8: Three-bit current level, 000 highest, 111 lowest; hardware or software writes.
// RULE9: Each new request compared to current level: pending or pre-empts.
// RULE10: Pre-empted level is saved to the nesting priority store.
// RULE11: Flags pushed on interrupt, restored at return; up to seven copies.
// RULE12: Carry out of bit 7 or 15; set, clear, complement instructions.
// RULE13: Zero flag set when accumulator result is zero after listed operations.
// RULE14: Sign flag copies bit 7 or bit 15 of the result.
// RULE15: Overflow flag set when two's-complement result is out of range.
// RULE16: BCD kind flag records addition or subtraction for decimal adjust.
// RULE17: Half carry from bit 3 on BCD add or subtract; flag bit 1 zero.
// RULE18: Data-pointer instr sets memory-area flag, code-pointer instr clears it.
// RULE19: Register file is 32 blocks of eight for working pointers.
// RULE20: Single mode rounds an odd block down to the even block.
// RULE21: Twin mode maps r0-r7 via first pointer, r8-r15 via second.
// RULE22: Group D reachable only as working registers, never direct addressing.
// RULE23: Low and high pointer instrs set pointer mode bit; single clears it.
// RULE24: Physical address is block number times eight plus index low bits.
module cscr_regs
  import cscr_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           nrst,
  input  wire logic [7:0]     reg_addr,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  input  wire logic [7:0]     reg_wdata,
  output logic [7:0]          reg_rdata,
  output logic                reg_rvalid,
  input  wire cscr_flag_cmd_t flag_cmd,
  input  wire cscr_ptr_op_t   ptr_op,
  input  wire logic [4:0]     ptr_blk,
  input  wire logic           irq_unmask_instr,
  input  wire logic           irq_mask_instr,
  input  wire logic           irq_ack,
  input  wire logic [2:0]     ack_level,
  input  wire logic           irq_return,
  input  wire logic [2:0]     restore_level,
  input  wire logic           tl_req,
  input  wire logic           tl_ack,
  input  wire logic           top_level_mask_sel,
  input  wire logic           timer_count_allow,
  input  wire logic           new_req_valid,
  input  wire logic [2:0]     new_req_level,
  input  wire logic [3:0]     wr_index,
  input  wire logic [7:0]     direct_addr,
  output logic                timer_run,
  output logic                irq_allowed,
  output logic                tl_ack_allowed,
  output logic                req_preempt,
  output logic                req_keep_pending,
  output logic                nest_save_valid,
  output logic [2:0]          nest_save_level,
  output logic [7:0]          interrupt_control_reg,
  output logic [7:0]          cpu_flag_reg,
  output logic                nested_mode,
  output logic                twin_mode,
  output logic [7:0]          wr_phys_addr,
  output logic                direct_addr_ok,
  output logic [2:0]          flag_stack_depth
);

  cscr_state_t st;
  cscr_state_t next_st;
  logic [7:0]  next_flags_alu;
  logic [`CSCR_STACK_DEPTH-1:0] push_slot;
  logic                         push_ok;
  logic                         pop_ok;

  // Blocks of eight registers: address is block times eight plus offset
  function automatic logic [7:0] blk_addr(input logic [4:0] blk,
                                          input logic [2:0] ofs);
    blk_addr = {blk, ofs}; // RULE24 RULE19
  endfunction

  // Group D is hidden from explicit register addressing
  function automatic logic in_group_d(input logic [7:0] addr);
    in_group_d = (addr[7:4] == `CSCR_GROUP_D);
  endfunction

  // Single mode always starts on an even block, whatever the pointer holds
  function automatic logic [4:0] pair_base(input logic [4:0] blk);
    pair_base = {blk[4:1], 1'b0}; // RULE20
  endfunction

  // Level zero is the most urgent, so a smaller code outranks a larger one
  function automatic logic outranks(input logic [2:0] lvl,
                                    input logic [2:0] cur);
    outranks = (lvl < cur); // RULE8
  endfunction

  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  function automatic logic [7:0] read_mux(input cscr_state_t s,
                                          input logic [7:0]  addr);
    unique case (addr)
      `CSCR_ADDR_ICR: read_mux = s.icr;
      `CSCR_ADDR_FLG: read_mux = s.flags;
      `CSCR_ADDR_RP0: read_mux = s.rp0;
      `CSCR_ADDR_RP1: read_mux = s.rp1;
      default:        read_mux = 8'h00;
    endcase
  endfunction

  cscr_flag_unit u_flag_unit (
    .flags_cur  (st.flags),
    .cmd        (flag_cmd),
    .flags_next (next_flags_alu)
  );

  // A full stack drops the push and an empty one the pop, so the depth
  // count never wraps and never hands back a stale copy
  assign push_ok = irq_ack && (st.depth != `CSCR_DEPTH_MAX); // RULE11
  assign pop_ok  = irq_return && (st.depth != 3'h0); // RULE11

  genvar g;
  generate
    for (g = 0; g < `CSCR_STACK_DEPTH; g++) begin : g_slot
      assign push_slot[g] = push_ok && (st.depth == 3'(g)); // RULE11
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.nest_save = 1'b0;
    next_st.rvalid = reg_rd;
    if (reg_rd) begin
      next_st.rdata = read_mux(st, reg_addr);
    end

    // Interrupt control: software first, hardware events override
    if (wr_hit(reg_wr, reg_addr, `CSCR_ADDR_ICR)) begin
      next_st.icr = reg_wdata; // RULE7 RULE8
    end
    if (irq_mask_instr) begin
      next_st.icr.allow = 1'b0; // RULE4
    end
    if (irq_unmask_instr) begin
      next_st.icr.allow = 1'b1; // RULE4
    end
    if (irq_return) begin
      next_st.icr.allow = 1'b1; // RULE4
      next_st.icr.cpl   = restore_level; // RULE8
    end
    if (irq_ack) begin
      next_st.icr.allow = 1'b0; // RULE4
      next_st.icr.cpl   = ack_level; // RULE8
      // Only a displaced routine of lower priority needs its level kept
      if (outranks(ack_level, st.icr.cpl)) begin
        next_st.nest_save  = 1'b1; // RULE10
        next_st.nest_level = st.icr.cpl; // RULE10
      end
    end
    if (tl_ack) begin
      next_st.icr.pend = 1'b0;
    end
    // A request in the clearing cycle still lands
    if (tl_req) begin
      next_st.icr.pend = 1'b1; // RULE2
    end

    // Flag register: instruction effects, then software, then restore
    next_st.flags = next_flags_alu;
    if (wr_hit(reg_wr, reg_addr, `CSCR_ADDR_FLG)) begin
      next_st.flags = reg_wdata & `CSCR_FLG_WMASK; // RULE17
    end
    // The copy pushed is the one before any change made in this cycle
    for (int k = 0; k < `CSCR_STACK_DEPTH; k++) begin
      if (push_slot[k]) begin
        next_st.stack[k] = st.flags; // RULE11
      end
    end
    if (push_ok) begin
      next_st.depth = st.depth + 3'h1; // RULE11
    end
    // Ack and return in one cycle both use the old depth; the core
    // never issues them together
    if (pop_ok) begin
      next_st.flags = st.stack[st.depth - 3'h1]; // RULE11
      next_st.depth = st.depth - 3'h1; // RULE11
    end

    // Working register pointers
    if (wr_hit(reg_wr, reg_addr, `CSCR_ADDR_RP0)) begin
      next_st.rp0 = reg_wdata & `CSCR_RP_WMASK;
    end
    if (wr_hit(reg_wr, reg_addr, `CSCR_ADDR_RP1)) begin
      next_st.rp1 = reg_wdata & `CSCR_RP_WMASK;
    end
    unique case (ptr_op)
      CSCR_P_NONE: ;
      CSCR_P_SINGLE: begin
        next_st.rp0.blk = pair_base(ptr_blk); // RULE20
        next_st.rp0.pointer_mode_sel = 1'b0; // RULE23
        next_st.rp1.pointer_mode_sel = 1'b0; // RULE23
      end
      CSCR_P_LOW: begin
        next_st.rp0.blk = ptr_blk; // RULE21
        next_st.rp0.pointer_mode_sel = 1'b1; // RULE23
        next_st.rp1.pointer_mode_sel = 1'b1; // RULE23
      end
      CSCR_P_HIGH: begin
        next_st.rp1.blk = ptr_blk; // RULE21
        next_st.rp0.pointer_mode_sel = 1'b1; // RULE23
        next_st.rp1.pointer_mode_sel = 1'b1; // RULE23
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{icr:        `CSCR_ICR_RST, // RULE1
              flags:      `CSCR_FLG_RST,
              rp0:        `CSCR_RP_RST,
              rp1:        `CSCR_RP_RST,
              stack:      '0,
              depth:      3'h0,
              rdata:      8'h00,
              rvalid:     1'b0,
              nest_save:  1'b0,
              nest_level: 3'h0};
    end else begin
      st <= next_st;
    end
  end

  // Decodes below read flops and live inputs; the core samples them in the same cycle
  always_comb begin
    timer_run = st.icr.gate & timer_count_allow; // RULE1
    irq_allowed = st.icr.allow; // RULE6
    // Mask select high masks the top-level source
    tl_ack_allowed = ~top_level_mask_sel
                     & (st.icr.tl_mode ? st.icr.allow : 1'b1); // RULE3
    req_preempt = new_req_valid & st.icr.allow
                  & outranks(new_req_level, st.icr.cpl); // RULE9
    req_keep_pending = new_req_valid & ~req_preempt; // RULE9
    if (!st.rp0.pointer_mode_sel) begin
      // Even base block plus index bit 3 selects the upper block
      // A software-written odd block must not shift the 16-register window
      wr_phys_addr = blk_addr(pair_base(st.rp0.blk) | {4'h0, wr_index[3]},
                              wr_index[2:0]); // RULE20 RULE24
    end else if (!wr_index[3]) begin
      wr_phys_addr = blk_addr(st.rp0.blk, wr_index[2:0]); // RULE21
    end else begin
      wr_phys_addr = blk_addr(st.rp1.blk, wr_index[2:0]); // RULE21
    end
    direct_addr_ok = ~in_group_d(direct_addr); // RULE22
  end

  assign reg_rdata             = st.rdata;
  assign reg_rvalid            = st.rvalid;
  assign nest_save_valid       = st.nest_save;
  assign nest_save_level       = st.nest_level;
  assign interrupt_control_reg = st.icr;
  assign cpu_flag_reg          = st.flags;
  assign nested_mode           = st.icr.arb; // RULE7
  assign twin_mode             = st.rp0.pointer_mode_sel;
  assign flag_stack_depth      = st.depth;

endmodule

`default_nettype wire

//--- tb/cscr_regs_props.sv
// Concurrent checks on the ports of the CPU system register block
`default_nettype none
module cscr_regs_props (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       irq_ack,
  input wire logic [2:0] ack_level,
  input wire logic       irq_return,
  input wire logic       tl_req,
  input wire logic       top_level_mask_sel,
  input wire logic       timer_count_allow,
  input wire logic       new_req_valid,
  input wire logic [2:0] new_req_level,
  input wire logic [7:0] direct_addr,
  input wire logic       timer_run,
  input wire logic       irq_allowed,
  input wire logic       tl_ack_allowed,
  input wire logic       req_preempt,
  input wire logic       nest_save_valid,
  input wire logic [2:0] nest_save_level,
  input wire logic [7:0] interrupt_control_reg,
  input wire logic [7:0] cpu_flag_reg,
  input wire logic       direct_addr_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_timer_gate: assert property (
    timer_run == (interrupt_control_reg[7] & timer_count_allow))
    else $error("timer run not gate and allow");
  chk_tl_pend: assert property (
    tl_req |=> interrupt_control_reg[6])
    else $error("top level request not pending");
  chk_tl_ack: assert property (
    tl_ack_allowed == (!top_level_mask_sel &&
      (!interrupt_control_reg[5] || interrupt_control_reg[4])))
    else $error("top level ack gating wrong");
  chk_ack_clear: assert property (
    irq_ack |=> !irq_allowed && interrupt_control_reg[2:0] == $past(ack_level))
    else $error("ack did not clear allow or load level");
  chk_return_set: assert property (
    irq_return && !irq_ack |=> irq_allowed)
    else $error("return did not set allow");
  chk_req_preempt: assert property (
    req_preempt == (new_req_valid && irq_allowed &&
      new_req_level < interrupt_control_reg[2:0]))
    else $error("preempt decision wrong");
  chk_nest_save: assert property (
    irq_ack && ack_level < interrupt_control_reg[2:0] |=> nest_save_valid &&
      nest_save_level == $past(interrupt_control_reg[2:0]))
    else $error("displaced level not saved");
  chk_rsv_flag: assert property (
    cpu_flag_reg[1] == 1'b0)
    else $error("reserved flag bit set");
  chk_group_d: assert property (
    direct_addr[7:4] == 4'hd |-> !direct_addr_ok)
    else $error("group d reachable directly");
endmodule
bind cscr_regs cscr_regs_props cscr_regs_props_i (
  .ref_clk               (ref_clk),
  .nrst                  (nrst),
  .irq_ack               (irq_ack),
  .ack_level             (ack_level),
  .irq_return            (irq_return),
  .tl_req                (tl_req),
  .top_level_mask_sel    (top_level_mask_sel),
  .timer_count_allow     (timer_count_allow),
  .new_req_valid         (new_req_valid),
  .new_req_level         (new_req_level),
  .direct_addr           (direct_addr),
  .timer_run             (timer_run),
  .irq_allowed           (irq_allowed),
  .tl_ack_allowed        (tl_ack_allowed),
  .req_preempt           (req_preempt),
  .nest_save_valid       (nest_save_valid),
  .nest_save_level       (nest_save_level),
  .interrupt_control_reg (interrupt_control_reg),
  .cpu_flag_reg          (cpu_flag_reg),
  .direct_addr_ok        (direct_addr_ok)
);
`default_nettype wire

//--- tb/test_cscr_regs.sv
// Self-checking bench for the CPU system register block
`default_nettype none
module test_cscr_regs
  import cscr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic           ref_clk = 1'b0;
  logic           nrst = 1'b0;
  logic           reg_wr, reg_rd, reg_rvalid, timer_count_allow;
  logic [7:0]     reg_addr, reg_wdata, reg_rdata, direct_addr, wr_phys_addr;
  logic [7:0]     interrupt_control_reg, cpu_flag_reg;
  cscr_flag_cmd_t flag_cmd;
  cscr_ptr_op_t   ptr_op;
  logic [4:0]     ptr_blk;
  logic [3:0]     wr_index;
  logic [2:0]     ack_level, restore_level, new_req_level, nest_save_level;
  logic [2:0]     flag_stack_depth;
  logic           irq_unmask_instr, irq_mask_instr, irq_ack, irq_return;
  logic           tl_req, tl_ack, top_level_mask_sel, new_req_valid;
  logic           timer_run, irq_allowed, tl_ack_allowed, req_preempt;
  logic           req_keep_pending, nest_save_valid, nested_mode;
  logic           twin_mode, direct_addr_ok;
  int             n_errors = 0;
  int             n_compared = 0;

  cscr_regs cscr_regs_i (
    .ref_clk               (ref_clk),
    .nrst                  (nrst),
    .reg_addr              (reg_addr),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .reg_rvalid            (reg_rvalid),
    .flag_cmd              (flag_cmd),
    .ptr_op                (ptr_op),
    .ptr_blk               (ptr_blk),
    .irq_unmask_instr      (irq_unmask_instr),
    .irq_mask_instr        (irq_mask_instr),
    .irq_ack               (irq_ack),
    .ack_level             (ack_level),
    .irq_return            (irq_return),
    .restore_level         (restore_level),
    .tl_req                (tl_req),
    .tl_ack                (tl_ack),
    .top_level_mask_sel    (top_level_mask_sel),
    .timer_count_allow     (timer_count_allow),
    .new_req_valid         (new_req_valid),
    .new_req_level         (new_req_level),
    .wr_index              (wr_index),
    .direct_addr           (direct_addr),
    .timer_run             (timer_run),
    .irq_allowed           (irq_allowed),
    .tl_ack_allowed        (tl_ack_allowed),
    .req_preempt           (req_preempt),
    .req_keep_pending      (req_keep_pending),
    .nest_save_valid       (nest_save_valid),
    .nest_save_level       (nest_save_level),
    .interrupt_control_reg (interrupt_control_reg),
    .cpu_flag_reg          (cpu_flag_reg),
    .nested_mode           (nested_mode),
    .twin_mode             (twin_mode),
    .wr_phys_addr          (wr_phys_addr),
    .direct_addr_ok        (direct_addr_ok),
    .flag_stack_depth      (flag_stack_depth)
  );

  always #10 ref_clk = ~ref_clk;

  task automatic step;
    @(negedge ref_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each driver steps once first so a strobe is never lowered and raised
  // again in the same time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    step;
    reg_addr = a;
    reg_rd = 1'b1;
    step;
    reg_rd = 1'b0;
    chk(8'(reg_rvalid), 8'h01);
    chk(reg_rdata, e);
  endtask

  task automatic pulse(ref logic s);
    step;
    s = 1'b1;
    step;
    s = 1'b0;
  endtask

  task automatic alu(input logic w, s, o, h, input logic [16:0] r);
    step;
    flag_cmd.alu = '{1'b1, w, 1'b1, 1'b1, s, r, o, h};
    step;
    flag_cmd = '0;
  endtask

  task automatic fop(input cscr_carry_op_t c, input cscr_mem_op_t m);
    step;
    flag_cmd.c_op = c;
    flag_cmd.m_op = m;
    step;
    flag_cmd = '0;
  endtask

  task automatic pop(input cscr_ptr_op_t o, input logic [4:0] b);
    step;
    ptr_op = o;
    ptr_blk = b;
    step;
    ptr_op = CSCR_P_NONE;
  endtask

  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    complete_run;
  end

  initial begin
    {reg_wr, reg_rd, irq_unmask_instr, irq_mask_instr, irq_ack} = '0;
    {irq_return, tl_req, tl_ack, top_level_mask_sel, new_req_valid} = '0;
    {reg_addr, reg_wdata, direct_addr, ack_level, restore_level} = '0;
    {new_req_level, ptr_blk, wr_index} = '0;
    flag_cmd = '0;
    ptr_op = CSCR_P_NONE;
    timer_count_allow = 1'b1;
    repeat (12) @(posedge ref_clk);
    step;
    nrst = 1'b1;
    rd(8'he6, 8'h87);
    rd(8'he7, 8'h00);
    rd(8'hd5, 8'h00);
    chk(8'(timer_run), 8'h01);
    wr(8'he6, 8'h07);
    chk(8'(timer_run), 8'h00);
    wr(8'he7, 8'hff);
    rd(8'he7, 8'hfd);
    pulse(tl_req);
    chk(interrupt_control_reg, 8'h47);
    pulse(tl_ack);
    chk(interrupt_control_reg, 8'h07);
    wr(8'he6, 8'h47);
    chk(interrupt_control_reg, 8'h47);
    for (int i = 0; i < 8; i++) begin
      top_level_mask_sel = i[0];
      wr(8'he6, {2'b00, i[2], i[1], 4'h7});
      chk(8'(tl_ack_allowed), 8'(!i[0] && (!i[2] || i[1])));
    end
    top_level_mask_sel = 1'b0;
    pulse(irq_mask_instr);
    chk(8'(irq_allowed), 8'h00);
    wr(8'he6, 8'h87);
    new_req_valid = 1'b1;
    new_req_level = 3'h6;
    pulse(irq_unmask_instr);
    chk(8'(req_preempt), 8'h01);
    pulse(irq_mask_instr);
    chk(8'(req_preempt), 8'h00);
    chk(8'(irq_allowed), 8'h00);
    pulse(irq_unmask_instr);
    new_req_level = 3'h7;
    step;
    chk(8'(req_preempt), 8'h00);
    chk(8'(req_keep_pending), 8'h01);
    new_req_valid = 1'b0;
    wr(8'he7, 8'h81);
    ack_level = 3'h2;
    pulse(irq_ack);
    chk(interrupt_control_reg, 8'h82);
    chk(8'(nest_save_valid), 8'h01);
    chk(8'(nest_save_level), 8'h07);
    chk(8'(flag_stack_depth), 8'h01);
    wr(8'he7, 8'h00);
    restore_level = 3'h7;
    pulse(irq_return);
    chk(interrupt_control_reg, 8'h97);
    chk(cpu_flag_reg, 8'h81);
    wr(8'he6, 8'h9f);
    ack_level = 3'h0;
    // Eight acks back to back, each rewriting the flags so that every slot
    // holds a different copy; the eighth finds the stack full
    reg_addr = 8'he7;
    for (int i = 0; i < 8; i++) begin
      irq_ack = 1'b1;
      reg_wr = 1'b1;
      reg_wdata = 8'(i * 16);
      step;
    end
    {irq_ack, reg_wr} = '0;
    chk(8'(flag_stack_depth), 8'h07);
    chk(cpu_flag_reg, 8'h70);
    chk(8'(nested_mode), 8'h01);
    // Copies come back newest first; the last return finds it empty
    for (int i = 0; i < 8; i++) begin
      irq_return = 1'b1;
      step;
      chk(cpu_flag_reg, i < 6 ? 8'((5 - i) * 16) : 8'h81);
    end
    irq_return = 1'b0;
    chk(8'(flag_stack_depth), 8'h00);
    chk(cpu_flag_reg, 8'h81);
    wr(8'he7, 8'h00);
    alu(1'b0, 1'b0, 1'b0, 1'b1, 17'h00100);
    chk(cpu_flag_reg, 8'hc4);
    alu(1'b1, 1'b1, 1'b1, 1'b0, 17'h08000);
    chk(cpu_flag_reg, 8'h38);
    fop(CSCR_C_SET, CSCR_M_KEEP);
    chk(cpu_flag_reg, 8'hb8);
    fop(CSCR_C_CLR, CSCR_M_KEEP);
    chk(cpu_flag_reg, 8'h38);
    fop(CSCR_C_CPL, CSCR_M_DATA);
    chk(cpu_flag_reg, 8'hb9);
    fop(CSCR_C_KEEP, CSCR_M_CODE);
    chk(cpu_flag_reg, 8'hb8);
    pop(CSCR_P_SINGLE, 5'd3);
    rd(8'he8, 8'h10);
    wr_index = 4'hd;
    step;
    chk(wr_phys_addr, 8'h1d);
    chk(8'(twin_mode), 8'h00);
    pop(CSCR_P_LOW, 5'd4);
    pop(CSCR_P_HIGH, 5'd9);
    rd(8'he8, 8'h24);
    rd(8'he9, 8'h4c);
    wr_index = 4'h2;
    step;
    chk(wr_phys_addr, 8'h22);
    wr_index = 4'ha;
    step;
    chk(wr_phys_addr, 8'h4a);
    chk(8'(twin_mode), 8'h01);
    direct_addr = 8'hd5;
    step;
    chk(8'(direct_addr_ok), 8'h00);
    direct_addr = 8'he6;
    step;
    chk(8'(direct_addr_ok), 8'h01);
    complete_run;
  end
endmodule
`default_nettype wire
